//--- hw/shlu_gpr_file.sv
/*
  general-purpose register array: three combinational read ports, two write ports.
  assumes both writes of one cycle never share an index; port a wins if they do.
*/
`timescale 1ns/100ps
`include "shlu_map.svh"

module shlu_gpr_file #(
  parameter int NREG = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wa_en,
  input wire shlu_pkg::shlu_idx_t wa_idx,
  input wire shlu_pkg::shlu_word_t wa_data,
  input wire logic wb_en,
  input wire shlu_pkg::shlu_idx_t wb_idx,
  input wire shlu_pkg::shlu_word_t wb_data,
  input wire shlu_pkg::shlu_idx_t ra_idx,
  output shlu_pkg::shlu_word_t ra_data,
  input wire shlu_pkg::shlu_idx_t rb_idx,
  output shlu_pkg::shlu_word_t rb_data,
  input wire shlu_pkg::shlu_idx_t rc_idx,
  output shlu_pkg::shlu_word_t rc_data
);

  shlu_pkg::shlu_word_t gpr [NREG];

  // ==========================================
  // one storage word per entry
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_ent
      wire hit_a = wa_en && (wa_idx == 5'(g));
      wire hit_b = wb_en && (wb_idx == 5'(g));
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          gpr[g] <= `SHLU_GPR_RST;
        else if (hit_a)
          gpr[g] <= wa_data;
        else if (hit_b)
          gpr[g] <= wb_data;
      end
    end
  endgenerate

  // read ports
  assign ra_data = gpr[ra_idx];
  assign rb_data = gpr[rb_idx];
  assign rc_data = gpr[rc_idx];

endmodule

//--- hw/shlu_map.svh
/*
  constants of the signed halfword load unit: opcodes, field positions, reset values.
  assumes a 32-bit instruction word held as [31:0], where documented bit k is bit 31-k.
*/
// Functional notes
// (RQ1) primary opcode 42 is the plain displacement load and 43 the updating one, fields target/base/offset.
// (RQ2) primary opcode 31 with extended opcode 343 is the plain indexed load and 375 the updating one.
// (RQ3) the 16-bit offset is sign-extended to 32 bits before address generation.
// (RQ4) displacement form with nonzero base field adds base register and extended offset.
// (RQ5) displacement form with zero base field uses the extended offset alone.
// (RQ6) indexed form with nonzero base field adds base register and index register.
// (RQ7) indexed form with zero base field uses the index register alone.
// (RQ8) the fetched halfword lands in the low 16 bits of the target register.
// (RQ9) the halfword sign bit is copied into the upper 16 bits of the target register.
// (RQ10) update forms write the address to the base register only if base is nonzero and not the target.
// (RQ11) the base write is dropped when the access reports an alignment or storage fault.
// (RQ12) these loads never write the fixed-point exception register or condition field 0.
// (RQ13) the last bit of the indexed encodings is ignored.
// (RQ14) storage returns the byte at the address in the upper half of the returned halfword.
`ifndef SHLU_MAP_SVH
`define SHLU_MAP_SVH

// ==========================================
// opcodes
`define SHLU_OP_DISP 6'h2a
`define SHLU_OP_DISP_UPD 6'h2b
`define SHLU_OP_EXT 6'h1f
`define SHLU_XO_IDX 10'h157
`define SHLU_XO_IDX_UPD 10'h177

// ==========================================
// field positions in the [31:0] word
`define SHLU_OPC_HI 31
`define SHLU_OPC_LO 26
`define SHLU_TGT_HI 25
`define SHLU_TGT_LO 21
`define SHLU_BASE_HI 20
`define SHLU_BASE_LO 16
`define SHLU_IDX_HI 15
`define SHLU_IDX_LO 11
`define SHLU_XO_HI 10
`define SHLU_XO_LO 1
`define SHLU_OFS_HI 15
`define SHLU_OFS_LO 0

// ==========================================
// reset values
`define SHLU_GPR_RST 32'h0000_0000
`define SHLU_ZERO_FIELD 5'h00

`endif

//--- hw/shlu_pkg.sv
/*
  types of the signed halfword load unit.
  assumes shlu_map.svh for the numeric constants.
*/
package shlu_pkg;

  // ==========================================
  // controller states
  typedef enum logic [0:0] {
    SHLU_IDLE = 1'b0,
    SHLU_ACCESS = 1'b1
  } shlu_state_e;

  // ==========================================
  // register index and word
  typedef logic [4:0] shlu_idx_t;
  typedef logic [31:0] shlu_word_t;

endpackage

//--- hw/shlu_top.sv
/*
  signed halfword load unit: decodes one instruction word, forms the address,
  fetches a halfword and writes the sign-extended result and optional base update.
  assumes a same-clock instruction source and a same-clock storage port answering
  with a one-cycle mem_ack together with data and fault flags.
*/
`timescale 1ns/100ps
`include "shlu_map.svh"

module shlu_top #(
  parameter int NREG = 32
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  output logic instr_ready_r,
  output logic done_r,
  output logic illegal_r,
  output logic fault_r,
  output logic base_upd_r,
  output logic [31:0] result_r,
  output logic [31:0] effective_address_r,
  output logic mem_req_r,
  output logic [31:0] mem_addr_r,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_align_fault,
  input wire logic mem_storage_fault,
  input wire logic preload_en,
  input wire logic [4:0] preload_idx,
  input wire logic [31:0] preload_data,
  input wire logic [4:0] peek_idx,
  output logic [31:0] peek_data_r,
  output logic xer_wr_en_r,
  output logic cr0_wr_en_r
);

  // ==========================================
  // reset release
  // the rest of the unit leaves reset only on a clock edge
  logic rst_s1_r;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ==========================================
  // decode of the incoming word
  // fields are read from the offered word itself, so a take needs no decode cycle
  wire [5:0] opc = instr_word[`SHLU_OPC_HI:`SHLU_OPC_LO];
  wire [9:0] xo = instr_word[`SHLU_XO_HI:`SHLU_XO_LO]; // bit 0 not decoded [RQ13]
  wire shlu_pkg::shlu_idx_t target_register_field = instr_word[`SHLU_TGT_HI:`SHLU_TGT_LO];
  wire shlu_pkg::shlu_idx_t base_register_field = instr_word[`SHLU_BASE_HI:`SHLU_BASE_LO];
  wire shlu_pkg::shlu_idx_t index_register_field = instr_word[`SHLU_IDX_HI:`SHLU_IDX_LO];
  wire [15:0] offset_field = instr_word[`SHLU_OFS_HI:`SHLU_OFS_LO];

  // form selection
  wire is_disp = (opc == `SHLU_OP_DISP); // [RQ1]
  wire is_disp_upd = (opc == `SHLU_OP_DISP_UPD); // [RQ1]
  wire is_ext = (opc == `SHLU_OP_EXT);
  wire is_idx = is_ext && (xo == `SHLU_XO_IDX); // [RQ2]
  wire is_idx_upd = is_ext && (xo == `SHLU_XO_IDX_UPD); // [RQ2]
  wire is_dform = is_disp || is_disp_upd;
  wire is_xform = is_idx || is_idx_upd;
  wire is_load = is_dform || is_xform;
  wire is_upd = is_disp_upd || is_idx_upd;

  // ==========================================
  // register file reads
  shlu_pkg::shlu_word_t base_val;
  shlu_pkg::shlu_word_t index_val;
  shlu_pkg::shlu_word_t peek_val;

  // ==========================================
  // address generation
  wire base_is_zero = (base_register_field == `SHLU_ZERO_FIELD);
  wire [31:0] ofs_ext = {{16{offset_field[15]}}, offset_field}; // [RQ3]
  wire [31:0] base_term = base_is_zero ? 32'h0000_0000 : base_val; // [RQ5] [RQ7]
  // register zero only means no base; as an index it is an ordinary register
  wire [31:0] second_term = is_dform ? ofs_ext : index_val;
  // base plus offset or index, wrapping at 32 bits
  wire [31:0] ea_nxt = 32'(base_term + second_term); // [RQ4] [RQ6]

  // ==========================================
  // update permission decided at decode time
  // deciding it at the take leaves only the fault gate for the answer cycle
  wire upd_allowed = is_upd && !base_is_zero
    && (base_register_field != target_register_field); // [RQ10]

  // ==========================================
  // controller state
  shlu_pkg::shlu_state_e state_r;
  shlu_pkg::shlu_state_e state_nxt;
  shlu_pkg::shlu_idx_t tgt_r;
  shlu_pkg::shlu_idx_t base_r;
  logic upd_ok_r;

  wire take = instr_ready_r && instr_valid;
  wire start = take && is_load;
  wire reject = take && !is_load;
  wire in_access = (state_r == shlu_pkg::SHLU_ACCESS);
  wire finish = in_access && mem_ack;
  wire any_fault = mem_align_fault || mem_storage_fault;

  // next-state selection
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      shlu_pkg::SHLU_IDLE:
      begin
        if (start)
          state_nxt = shlu_pkg::SHLU_ACCESS;
      end
      shlu_pkg::SHLU_ACCESS:
      begin
        if (mem_ack)
          state_nxt = shlu_pkg::SHLU_IDLE;
      end
    endcase
  end

  // ==========================================
  // result forming and write-back
  wire [31:0] load_val = {{16{mem_rdata[15]}}, mem_rdata}; // [RQ8] [RQ9] [RQ14]
  // a faulted access writes no register at all
  wire clean_finish = finish && !any_fault;
  wire tgt_we = clean_finish;
  // base update is dropped on either kind of fault
  wire base_we = clean_finish && upd_ok_r; // [RQ10] [RQ11]
  // a preload yields to a load, so write port a never has two sources
  wire idle_preload = preload_en && !in_access && !start;
  wire wa_en = tgt_we || idle_preload;
  wire shlu_pkg::shlu_idx_t wa_idx = tgt_we ? tgt_r : preload_idx;
  wire [31:0] wa_data = tgt_we ? load_val : preload_data;

  shlu_gpr_file #(
    .NREG(NREG)
  ) u_gpr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wa_en(wa_en),
    .wa_idx(wa_idx),
    .wa_data(wa_data),
    .wb_en(base_we),
    .wb_idx(base_r),
    .wb_data(effective_address_r),
    .ra_idx(base_register_field),
    .ra_data(base_val),
    .rb_idx(index_register_field),
    .rb_data(index_val),
    .rc_idx(peek_idx),
    .rc_data(peek_val)
  );

  // ==========================================
  // state and captured fields
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= shlu_pkg::SHLU_IDLE;
    else
      state_r <= state_nxt;
  end

  // fields held for the write-back cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgt_r <= `SHLU_ZERO_FIELD;
      base_r <= `SHLU_ZERO_FIELD;
      upd_ok_r <= 1'b0;
    end
    else if (start)
    begin
      tgt_r <= target_register_field;
      base_r <= base_register_field;
      upd_ok_r <= upd_allowed;
    end
  end

  // ==========================================
  // storage request, held from the take until the answer edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mem_req_r <= 1'b0;
    else if (start)
      mem_req_r <= 1'b1;
    else if (finish)
      mem_req_r <= 1'b0;
  end

  // address stays still for the whole access and is shown after it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_addr_r <= 32'h0000_0000;
      effective_address_r <= 32'h0000_0000;
    end
    else if (start)
    begin
      mem_addr_r <= ea_nxt;
      effective_address_r <= ea_nxt;
    end
  end

  // ==========================================
  // handshake toward the instruction source
  // ready falls at the take of a load and rises at the answer edge: one load in flight
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      instr_ready_r <= 1'b0;
    else if (start)
      instr_ready_r <= 1'b0;
    else
      instr_ready_r <= !in_access || mem_ack;
  end

  // ==========================================
  // completion pulses of a load, one cycle each
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      done_r <= finish;
      fault_r <= finish && any_fault; // [RQ11]
    end
  end

  // base write shown beside the done pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      base_upd_r <= 1'b0;
    else
      base_upd_r <= base_we; // [RQ10]
  end

  // refusal pulse for a word that is none of the four loads
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      illegal_r <= 1'b0;
    else
      illegal_r <= reject; // [RQ1] [RQ2]
  end

  // loaded value shown beside the done pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      result_r <= 32'h0000_0000;
    else if (tgt_we)
      result_r <= load_val;
  end

  // ==========================================
  // status registers are never written by these loads
  // kept as outputs so that an enclosing core can see that no flag write leaks out
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xer_wr_en_r <= 1'b0;
      cr0_wr_en_r <= 1'b0;
    end
    else
    begin
      xer_wr_en_r <= 1'b0; // [RQ12]
      cr0_wr_en_r <= 1'b0; // [RQ12]
    end
  end

  // ==========================================
  // register peek port, one cycle behind the index
  // it shows the writes of the edge before, never a bypassed value
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      peek_data_r <= 32'h0000_0000;
    else
      peek_data_r <= peek_val;
  end

endmodule

//--- tb/shlu_chk_sva.sv
/*
  port checker of the load unit.
  assumes it is bound onto shlu_top.
*/
`timescale 1ns/100ps
module shlu_chk #(
  parameter int NREG = 32
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic instr_ready_r,
  input wire logic done_r,
  input wire logic illegal_r,
  input wire logic fault_r,
  input wire logic base_upd_r,
  input wire logic [31:0] result_r,
  input wire logic mem_req_r,
  input wire logic [31:0] mem_addr_r,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_align_fault,
  input wire logic mem_storage_fault,
  input wire logic xer_wr_en_r,
  input wire logic cr0_wr_en_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // decode of the offered and the held word
  logic [31:0] word_r;
  wire take = instr_valid && instr_ready_r;
  wire [5:0] op = instr_word[31:26];
  wire [9:0] xo = instr_word[10:1];
  wire ld = op[5:1] == 5'h15 || (op == 6'h1f && (xo == 10'h157 || xo == 10'h177));
  wire disp0 = op[5:1] == 5'h15 && instr_word[20:16] == 5'h00;
  wire upd = word_r[31:26] == 6'h2b || (word_r[31:26] == 6'h1f && word_r[10:1] == 10'h177);
  wire upd_ok = upd && word_r[20:16] != 5'h00 && word_r[20:16] != word_r[25:21];
  wire flt = mem_align_fault || mem_storage_fault;
  // hold the word of the load in flight
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      word_r <= 32'h0;
    else if (take)
      word_r <= instr_word;
  // ==========================================
  // assertions
  AST_TAKE_LOAD: assert property (
    take && ld |=> mem_req_r && !instr_ready_r && !illegal_r)
    else $error("load word not started");
  AST_TAKE_ILL: assert property (take && !ld |=> illegal_r && !mem_req_r)
    else $error("foreign word not refused");
  AST_DISP_ZERO: assert property (
    take && disp0 |=> mem_addr_r == {{16{word_r[15]}}, word_r[15:0]})
    else $error("zero base address wrong");
  AST_ADDR_HOLD: assert property (
    mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r))
    else $error("address moved during request");
  AST_DONE: assert property (
    mem_req_r && mem_ack |=> done_r && !mem_req_r && instr_ready_r)
    else $error("no completion after answer");
  AST_LOW_HALF: assert property (
    mem_req_r && mem_ack && !flt |=> result_r[15:0] == $past(mem_rdata))
    else $error("low half wrong");
  AST_SIGN: assert property (done_r && !fault_r |-> result_r[31:16] == {16{result_r[15]}})
    else $error("sign copy wrong");
  AST_FAULT: assert property (mem_req_r && mem_ack && flt |=> fault_r && !base_upd_r)
    else $error("fault not honoured");
  AST_UPD: assert property (done_r && !fault_r |-> base_upd_r == upd_ok)
    else $error("base update wrong");
  AST_NO_FLAGS: assert property (!xer_wr_en_r && !cr0_wr_en_r)
    else $error("flag register written");
  COV_UPD: cover property (done_r && base_upd_r);
  COV_FLT: cover property (fault_r);
  COV_ILL: cover property (illegal_r);
endmodule

//--- tb/shlu_mem_model.sv
/*
  storage partner of the load unit: answers each request after a set number of cycles.
  assumes the bench sets latency and fault flags before each load.
*/
`timescale 1ns/100ps
module shlu_mem_model (
  input wire logic sys_clk,
  input wire logic mem_req_r,
  input wire logic [31:0] mem_addr_r,
  input wire logic [1:0] lat,
  input wire logic al_f,
  input wire logic st_f,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output logic mem_align_fault,
  output logic mem_storage_fault
);
  logic [1:0] cnt = 2'h0;
  // ==========================================
  // storage contents
  function automatic logic [7:0] mbyte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h96;
  endfunction
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    mem_align_fault = 1'b0;
    mem_storage_fault = 1'b0;
  end
  // answer after lat waiting cycles; idle lines toggle so stale data never matches
  always @(posedge sys_clk)
  begin
    if (mem_req_r && !mem_ack && cnt == lat)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= {mbyte(mem_addr_r), mbyte(mem_addr_r + 32'h1)};
      mem_align_fault <= al_f;
      mem_storage_fault <= st_f;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mem_align_fault <= ~mem_align_fault;
      mem_storage_fault <= ~mem_storage_fault;
    end
    cnt <= (mem_req_r && !mem_ack) ? cnt + 2'h1 : 2'h0;
  end
endmodule

//--- tb/tb_signed_halfword_load_unit.sv
/*
  random load bench of the load unit compared with a register model.
  assumes shlu_top, shlu_mem_model and shlu_chk.
*/
`timescale 1ns/100ps
module tb_signed_halfword_load_unit;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic preload_en = 1'b0;
  logic [4:0] preload_idx = 5'h0;
  logic [31:0] preload_data = 32'h0;
  logic [4:0] peek_idx = 5'h0;
  logic [1:0] lat = 2'h0;
  logic al_f = 1'b0;
  logic st_f = 1'b0;
  wire instr_ready_r, done_r, illegal_r, fault_r, base_upd_r, mem_req_r, mem_ack;
  wire mem_align_fault, mem_storage_fault, xer_wr_en_r, cr0_wr_en_r;
  wire [31:0] result_r, effective_address_r, mem_addr_r, peek_data_r;
  wire [15:0] mem_rdata;
  logic [31:0] gpr [32];
  int mismatches = 0;
  int total_checks = 0;
  // clock of 50 ns
  always #25 sys_clk = ~sys_clk;
  shlu_top #(.NREG(32)) DUT (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready_r(instr_ready_r), .done_r(done_r),
    .illegal_r(illegal_r), .fault_r(fault_r), .base_upd_r(base_upd_r), .result_r(result_r),
    .effective_address_r(effective_address_r), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_align_fault(mem_align_fault),
    .mem_storage_fault(mem_storage_fault), .preload_en(preload_en), .preload_idx(preload_idx),
    .preload_data(preload_data), .peek_idx(peek_idx), .peek_data_r(peek_data_r),
    .xer_wr_en_r(xer_wr_en_r), .cr0_wr_en_r(cr0_wr_en_r));
  shlu_mem_model mem (.sys_clk(sys_clk), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
    .lat(lat), .al_f(al_f), .st_f(st_f), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_align_fault(mem_align_fault), .mem_storage_fault(mem_storage_fault));
  // ==========================================
  // helpers
  function automatic logic [7:0] mbyte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h96;
  endfunction
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (n >= 50)
    begin
      mismatches++;
      finish_test;
    end
  endtask
  task preload(input logic [4:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    preload_en <= 1'b1;
    preload_idx <= i;
    preload_data <= d;
    gpr[i] = d;
    @(posedge sys_clk);
    preload_en <= 1'b0;
  endtask
  task peek(input logic [4:0] i);
    @(posedge sys_clk);
    peek_idx <= i;
    repeat (2) @(posedge sys_clk);
    chk(peek_data_r, gpr[i]);
  endtask
  // ==========================================
  // one instruction against the model
  task automatic run(input logic [31:0] w, input logic flt);
    logic [4:0] t, b;
    logic ld, upd, wb;
    logic [31:0] ea, res;
    logic [15:0] h;
    int n;
    t = w[25:21];
    b = w[20:16];
    ld = w[31:27] == 5'h15 || (w[31:26] == 6'h1f && (w[10:1] == 10'h157 || w[10:1] == 10'h177));
    upd = w[31:26] == 6'h2b || (w[31:26] == 6'h1f && w[10:1] == 10'h177);
    ea = b == 5'h0 ? 32'h0 : gpr[b];
    ea = ea + (w[31:27] == 5'h15 ? {{16{w[15]}}, w[15:0]} : gpr[w[15:11]]);
    h = {mbyte(ea), mbyte(ea + 32'h1)};
    res = {{16{h[15]}}, h};
    wb = upd && b != 5'h0 && b != t && !flt;
    for (n = 0; n < 50 && instr_ready_r !== 1'b1; n++) @(posedge sys_clk);
    tmo(n);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    for (n = 0; n < 50 && done_r !== 1'b1 && illegal_r !== 1'b1; n++) @(posedge sys_clk);
    tmo(n);
    chk(32'(illegal_r), 32'(!ld));
    chk(32'({xer_wr_en_r, cr0_wr_en_r}), 32'h0);
    if (ld)
    begin
      chk(effective_address_r, ea);
      chk(mem_addr_r, ea);
      chk(32'(fault_r), 32'(flt));
      chk(32'(base_upd_r), 32'(wb));
      if (!flt)
      begin
        chk(result_r, res);
        gpr[t] = res;
      end
      if (wb)
        gpr[b] = ea;
    end
    peek(t);
    peek(b);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    logic [31:0] w;
    logic [4:0] t, b, x;
    void'($urandom(32'h5dbb1b92));
    for (int i = 0; i < 32; i++) gpr[i] = 32'h0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) preload(5'(i), $urandom);
    for (int i = 0; i < 100; i++)
    begin
      preload(5'($urandom % 4), $urandom);
      t = 5'($urandom % 4);
      b = 5'($urandom % 4);
      x = 5'($urandom % 4);
      w = {6'h1f, t, b, x, 10'h14b, 1'($urandom)};
      case (i % 5)
        0: w = {6'h2a, t, b, 16'($urandom)};
        1: w = {6'h2b, t, b, 16'($urandom)};
        2: w = {6'h1f, t, b, x, 10'h157, 1'($urandom)};
        3: w = {6'h1f, t, b, x, 10'h177, 1'($urandom)};
        default: w = w;
      endcase
      lat <= 2'($urandom);
      al_f <= ($urandom % 6) == 0;
      st_f <= ($urandom % 6) == 0;
      @(posedge sys_clk);
      run(w, al_f | st_f);
    end
    $display("random load test done");
    finish_test;
  end
endmodule
bind shlu_top shlu_chk #(.NREG(NREG)) chk_i (.sys_clk, .rstn, .instr_valid, .instr_word,
  .instr_ready_r, .done_r, .illegal_r, .fault_r, .base_upd_r, .result_r, .mem_req_r,
  .mem_addr_r, .mem_ack, .mem_rdata, .mem_align_fault, .mem_storage_fault, .xer_wr_en_r,
  .cr0_wr_en_r);
